// >>> design/tsls_pkg.sv
package tsls_pkg;

    // Clock, the one-second base of the delays, and the button repeat times in milliseconds
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned SEC_S = 1;
    localparam int unsigned SEC_CYC_DEF = CLK_HZ * SEC_S;
    localparam int unsigned REP_START_MS = 500;
    localparam int unsigned REP_PERIOD_MS = 100;
    localparam int unsigned REP_START_DEF = (CLK_HZ / 1000) * REP_START_MS;
    localparam int unsigned REP_PERIOD_DEF = (CLK_HZ / 1000) * REP_PERIOD_MS;

    // Settings: percent of range and seconds, 7 bits each
    localparam logic [6:0] VAL_MIN = 7'h00;
    localparam logic [6:0] VAL_MAX = 7'h64;
    localparam logic [6:0] UPPER_RST = 7'h50;
    localparam logic [6:0] LOWER_RST = 7'h14;
    localparam logic [6:0] DELAY_RST = 7'h00;
    localparam int PMIL_PER_PCT = 10;

    // Loop currents in microamperes
    localparam logic [15:0] UA_4 = 16'h0fa0;
    localparam logic [15:0] UA_20 = 16'h4e20;
    localparam logic [15:0] UA_SAT_LO = 16'h0ed8;
    localparam logic [15:0] UA_SAT_HI = 16'h5014;
    localparam logic [15:0] UA_FAULT_HI = 16'h55f0;
    localparam logic [15:0] UA_FAULT_LO = 16'h0e10;
    localparam int UA_PER_PMIL = 16;

    // Rotary switch positions
    localparam logic [3:0] MENU_UP_DLY = 4'h3;
    localparam logic [3:0] MENU_LO_DLY = 4'h4;
    localparam logic [3:0] MENU_UP_THR = 4'h5;
    localparam logic [3:0] MENU_LO_THR = 4'h6;
    localparam logic [3:0] MENU_MODE = 4'h7;

    // APB map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SETTINGS = 8'h08;
    localparam logic [7:0] ADDR_LOOP = 8'h0c;
    localparam int CTRL_FALL_BIT = 0;
    localparam int CTRL_FSIG_LSB = 1;
    localparam int ST_COVERED_BIT = 2;
    localparam int ST_FAULT_BIT = 3;
    localparam int ST_PEND_BIT = 4;
    localparam logic [1:0] FSIG_OFF = 2'h0;
    localparam logic [1:0] FSIG_HI = 2'h1;
    localparam logic [1:0] FSIG_LO = 2'h2;

    typedef enum logic [1:0] {MODE_ANALOG, MODE_HIGH, MODE_LOW} tsls_mode_t;
    typedef enum logic [2:0] {DISP_VALUE, DISP_DASH, DISP_C_AN, DISP_C_HI, DISP_C_LO} tsls_disp_t;

endpackage

// >>> design/tsls_top.sv
// Operation
// - Covered state only after level above upper threshold for the whole activation delay.
// - Uncovered state only after level below lower threshold for the whole deactivation delay.
// - Level leaving above-upper before expiry restarts the activation timer.
// - Level leaving below-lower before expiry restarts the deactivation timer.
// - Delays in seconds; both buttons toggle a delay between 0 and 100.
// - Probe covered when level percent exceeds the upper threshold.
// - Probe uncovered when level percent is below the lower threshold.
// - In analog mode threshold and delay items are locked and show dashes.
// - Two-state high drives 20 mA covered, 4 mA uncovered.
// - Two-state low drives 4 mA covered, 20 mA uncovered.
// - After reset the output is in proportional analog mode.
// - Fault signalling overrides the current chosen by the mode.
// - Mode item: increment held over 1 s picks high, decrement picks low.
// - Both buttons held over 1 s return to analog; display shows analog code.
// - A two-state selection changes the current only on button release.
// - Analog current saturates at 3.8 and 20.5 mA.
// - Analog current proportional to percent, rising or falling over 4 to 20 mA.
// - Mode item with no button pressed shows the present loop current.
// - Short press steps a setting once; holding repeats the step.
// - High fault signalling forces 22.0 mA on fault.
// - Low fault signalling forces 3.6 mA on fault.
`timescale 1ns/1ps
`default_nettype none

module tsls_top import tsls_pkg::*; #(
    parameter int unsigned SEC_CYCLES = SEC_CYC_DEF,
    parameter int unsigned REP_START_CYCLES = REP_START_DEF,
    parameter int unsigned REP_PERIOD_CYCLES = REP_PERIOD_DEF
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Measurement and diagnostics, same clock
    input wire logic signed [15:0] level_pmil,
    input wire logic fault,
    // Front panel pins
    input wire logic btn_inc_n,
    input wire logic btn_dec_n,
    input wire logic [3:0] menu_sel,
    // Loop setpoint and display
    output logic [15:0] loop_ua,
    output logic covered,
    output tsls_disp_t disp_code,
    output logic [15:0] disp_value
);

    generate
        if (SEC_CYCLES < 2 || REP_PERIOD_CYCLES < 1 || REP_START_CYCLES >= SEC_CYCLES) begin : g_bad
            $error("tsls_top: timing parameters out of range");
        end
    endgenerate

    // Pin synchronisers: a change is accepted once stages two and three agree
    logic [5:0] pin_s1_reg;
    logic [5:0] pin_s2_reg;
    logic [5:0] pin_s3_reg;
    logic [5:0] pin_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 6'h3f;
            pin_s2_reg <= 6'h3f;
            pin_s3_reg <= 6'h3f;
            pin_reg <= 6'h3f;
        end else begin
            pin_s1_reg <= {btn_inc_n, btn_dec_n, menu_sel};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (pin_s2_reg == pin_s3_reg) begin
                pin_reg <= pin_s3_reg;
            end
        end
    end

    logic [1:0] btn;
    logic [3:0] menu;
    assign btn = ~pin_reg[5:4];
    assign menu = pin_reg[3:0];

    // Button hold timing
    // Steps fire on the press edge, then repeat while the button stays down
    logic [1:0] btn_prev_reg;
    logic [31:0] hold_reg;
    logic [31:0] rep_reg;
    logic btn_chg;
    logic long_hit;
    logic held_long;
    logic rep_tick;
    logic step_inc;
    logic step_dec;
    logic both_edge;

    assign btn_chg = btn != btn_prev_reg;
    assign long_hit = !btn_chg && btn != 2'b00 && hold_reg == SEC_CYCLES - 1;
    assign held_long = hold_reg >= SEC_CYCLES - 1;
    assign rep_tick = !btn_chg && hold_reg >= REP_START_CYCLES && rep_reg == REP_PERIOD_CYCLES - 1;
    assign step_inc = btn == 2'b10 && ((btn_chg && btn_prev_reg == 2'b00) || rep_tick);
    assign step_dec = btn == 2'b01 && ((btn_chg && btn_prev_reg == 2'b00) || rep_tick);
    assign both_edge = btn_chg && btn == 2'b11;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_prev_reg <= 2'b00;
            hold_reg <= 32'h0;
            rep_reg <= 32'h0;
        end else begin
            btn_prev_reg <= btn;
            if (btn_chg) begin
                hold_reg <= 32'h0;
            end else if (hold_reg < SEC_CYCLES) begin
                hold_reg <= hold_reg + 32'h1;
            end
            if (btn_chg || hold_reg < REP_START_CYCLES || rep_reg == REP_PERIOD_CYCLES - 1) begin
                rep_reg <= 32'h0;
            end else begin
                rep_reg <= rep_reg + 32'h1;
            end
        end
    end

    // Mode selection
    // A two-state choice waits in pend_reg until every button is up
    tsls_mode_t mode_reg;
    tsls_mode_t pend_reg;
    logic pend_valid_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= MODE_ANALOG;
            pend_reg <= MODE_ANALOG;
            pend_valid_reg <= 1'b0;
        end else begin
            if (long_hit && btn == 2'b11) begin
                mode_reg <= MODE_ANALOG;
                pend_valid_reg <= 1'b0;
            end else if (long_hit && menu == MENU_MODE) begin
                pend_reg <= (btn == 2'b10) ? MODE_HIGH : MODE_LOW;
                pend_valid_reg <= 1'b1;
            end else if (pend_valid_reg && btn == 2'b00) begin
                mode_reg <= pend_reg;
                pend_valid_reg <= 1'b0;
            end
        end
    end

    // Threshold and delay settings from the buttons
    logic [6:0] upper_reg;
    logic [6:0] lower_reg;
    logic [6:0] act_dly_reg;
    logic [6:0] deact_dly_reg;
    logic adjust_ok;

    assign adjust_ok = mode_reg != MODE_ANALOG;

    function automatic logic [6:0] step_val(input logic [6:0] v, input logic up, input logic dn);
        logic [6:0] r;
        r = v;
        if (up && v < VAL_MAX) begin
            r = v + 7'h01;
        end else if (dn && v > VAL_MIN) begin
            r = v - 7'h01;
        end
        return r;
    endfunction

    function automatic logic [6:0] toggle_val(input logic [6:0] v);
        return (v == VAL_MAX) ? VAL_MIN : VAL_MAX;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_reg <= UPPER_RST;
            lower_reg <= LOWER_RST;
            act_dly_reg <= DELAY_RST;
            deact_dly_reg <= DELAY_RST;
        end else if (adjust_ok) begin
            case (menu)
                MENU_UP_DLY: begin
                    act_dly_reg <= both_edge ? toggle_val(act_dly_reg) :
                        step_val(act_dly_reg, step_inc, step_dec);
                end
                MENU_LO_DLY: begin
                    deact_dly_reg <= both_edge ? toggle_val(deact_dly_reg) :
                        step_val(deact_dly_reg, step_inc, step_dec);
                end
                MENU_UP_THR: begin
                    upper_reg <= step_val(upper_reg, step_inc, step_dec);
                end
                MENU_LO_THR: begin
                    lower_reg <= step_val(lower_reg, step_inc, step_dec);
                end
                default: begin
                end
            endcase
        end
    end

    // Level decisions, signed so that a level below zero never reads as above
    int level_i;
    int upper_i;
    int lower_i;
    logic above;
    logic below;
    assign level_i = int'(level_pmil);
    assign upper_i = int'(upper_reg) * PMIL_PER_PCT;
    assign lower_i = int'(lower_reg) * PMIL_PER_PCT;
    assign above = level_i > upper_i;
    assign below = level_i < lower_i;

    // Activation (0) and deactivation (1) timers, each with its own second prescaler
    // A delay of zero lets the output follow on the first qualifying cycle
    logic [1:0] cond;
    logic [1:0] done;
    logic [6:0] dly [2];
    assign cond = {below, above};
    assign dly[0] = act_dly_reg;
    assign dly[1] = deact_dly_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            logic [31:0] sub_reg;
            logic [6:0] sec_reg;
            assign done[gi] = cond[gi] && sec_reg >= dly[gi];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sub_reg <= 32'h0;
                    sec_reg <= 7'h00;
                end else if (!cond[gi]) begin
                    sub_reg <= 32'h0;
                    sec_reg <= 7'h00;
                end else if (sec_reg < dly[gi]) begin
                    if (sub_reg == SEC_CYCLES - 1) begin
                        sub_reg <= 32'h0;
                        sec_reg <= sec_reg + 7'h01;
                    end else begin
                        sub_reg <= sub_reg + 32'h1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            covered <= 1'b0;
        end else if (done[0]) begin
            covered <= 1'b1;
        end else if (done[1]) begin
            covered <= 1'b0;
        end else begin
            covered <= covered;
        end
    end
    // Between the thresholds neither timer ends, so the state holds

    // APB control register
    logic fall_reg;
    logic [1:0] fsig_reg;

    // Loop current
    logic [15:0] loop_next;
    logic [15:0] analog_ua;
    int prop;

    always_comb begin
        prop = 32'(level_pmil) * UA_PER_PMIL;
        prop = fall_reg ? int'(UA_20) - prop : int'(UA_4) + prop;
        if (prop < int'(UA_SAT_LO)) begin
            analog_ua = UA_SAT_LO;
        end else if (prop > int'(UA_SAT_HI)) begin
            analog_ua = UA_SAT_HI;
        end else begin
            analog_ua = prop[15:0];
        end
        case (mode_reg)
            MODE_HIGH: loop_next = covered ? UA_20 : UA_4;
            MODE_LOW: loop_next = covered ? UA_4 : UA_20;
            default: loop_next = analog_ua;
        endcase
        // Fault signalling is applied last so it beats every mode
        if (fault && fsig_reg == FSIG_HI) begin
            loop_next = UA_FAULT_HI;
        end else if (fault && fsig_reg == FSIG_LO) begin
            loop_next = UA_FAULT_LO;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_ua <= UA_4;
        end else begin
            loop_ua <= loop_next;
        end
    end

    // Display
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_code <= DISP_VALUE;
            disp_value <= 16'h0;
        end else begin
            disp_code <= DISP_VALUE;
            disp_value <= level_pmil;
            if (btn == 2'b11 && held_long) begin
                disp_code <= DISP_C_AN;
            end else if (pend_valid_reg) begin
                disp_code <= (pend_reg == MODE_HIGH) ? DISP_C_HI : DISP_C_LO;
            end else if (menu >= MENU_UP_DLY && menu <= MENU_LO_THR && !adjust_ok) begin
                disp_code <= DISP_DASH;
            end else begin
                case (menu)
                    MENU_UP_DLY: disp_value <= {9'h0, act_dly_reg};
                    MENU_LO_DLY: disp_value <= {9'h0, deact_dly_reg};
                    MENU_UP_THR: disp_value <= {9'h0, upper_reg};
                    MENU_LO_THR: disp_value <= {9'h0, lower_reg};
                    MENU_MODE: disp_value <= loop_ua;
                    default: disp_value <= level_pmil;
                endcase
            end
        end
    end

    // APB slave, zero wait states
    // Read data is captured in the setup cycle and stands through the access phase
    logic addr_ok;
    logic [31:0] rd_mux;
    assign pready = 1'b1;
    assign addr_ok = paddr == ADDR_CTRL || paddr == ADDR_STATUS ||
        paddr == ADDR_SETTINGS || paddr == ADDR_LOOP;
    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        case (paddr)
            ADDR_CTRL: rd_mux = {29'h0, fsig_reg, fall_reg};
            ADDR_STATUS: rd_mux = {27'h0, pend_valid_reg, fault, covered, mode_reg};
            ADDR_SETTINGS: rd_mux = {1'b0, deact_dly_reg, 1'b0, act_dly_reg,
                1'b0, lower_reg, 1'b0, upper_reg};
            ADDR_LOOP: rd_mux = {16'h0, loop_ua};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_reg <= 1'b0;
            fsig_reg <= FSIG_OFF;
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
            fall_reg <= pwdata[CTRL_FALL_BIT];
            fsig_reg <= pwdata[CTRL_FSIG_LSB +: 2];
        end
    end

endmodule

`default_nettype wire

// >>> tb/test_two_state_level_switch_output.sv
`timescale 1ns/1ps
`default_nettype none

module test_two_state_level_switch_output import tsls_pkg::*; ();
    localparam int SEC = 100;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [15:0] level_set = 16'sh0000;
    logic fault_set = 1'h0;
    logic signed [15:0] level_pmil;
    logic fault;
    logic btn_inc_n = 1'h1;
    logic btn_dec_n = 1'h1;
    logic [3:0] menu_sel = 4'h0;
    logic [15:0] loop_ua;
    logic covered;
    tsls_disp_t disp_code;
    logic [15:0] disp_value;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    always #2.5 pclk = ~pclk;
    tsls_top #(.SEC_CYCLES(SEC), .REP_START_CYCLES(50), .REP_PERIOD_CYCLES(10)) u_tsls_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .level_pmil(level_pmil), .fault(fault), .btn_inc_n(btn_inc_n), .btn_dec_n(btn_dec_n),
        .menu_sel(menu_sel), .loop_ua(loop_ua), .covered(covered), .disp_code(disp_code),
        .disp_value(disp_value)
    );
    tsls_probe_model u_tsls_probe_model (
        .pclk(pclk), .presetn(presetn), .level_set(level_set), .fault_set(fault_set),
        .level_pmil(level_pmil), .fault(fault)
    );
    task automatic test_done;
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer; read data and error taken at the completing edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic press(input logic i, input logic d, input int n);
        btn_inc_n <= ~i;
        btn_dec_n <= ~d;
        wt(n);
    endtask
    task automatic rel;
        press(1'h0, 1'h0, 20);
    endtask
    task automatic menu(input logic [3:0] m);
        menu_sel <= m;
        wt(8);
    endtask
    task automatic chk_loop(input logic [15:0] e);
        chk("loop_ua", {16'h0, e}, {16'h0, loop_ua});
    endtask
    task automatic wait_cov(input logic v, input int n);
        int k;
        k = 0;
        while (covered !== v && k < n) begin
            @(posedge pclk);
            k++;
        end
        chk("covered", {31'h0, v}, {31'h0, covered});
    endtask
    task automatic t_reset;
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'h0, ADDR_SETTINGS, 32'h0);
        chk("settings", 32'h00001450, rd);
        apb(1'h0, 8'h10, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        apb(1'h1, ADDR_LOOP, 32'h00001234);
        apb(1'h0, ADDR_LOOP, 32'h0);
        chk("loop_reg", {16'h0, UA_4}, rd);
    endtask
    task automatic t_analog;
        logic signed [15:0] lv [4] = '{16'sh01f4, 16'sh044c, -16'sh0064, 16'sh00fa};
        logic [15:0] ex [4] = '{16'h2ee0, 16'h5014, 16'h0ed8, 16'h3e80};
        for (int i = 0; i < 4; i++) begin
            if (i == 3) begin
                apb(1'h1, ADDR_CTRL, 32'h1);
            end
            level_set <= lv[i];
            wt(5);
            chk_loop(ex[i]);
        end
        apb(1'h1, ADDR_CTRL, 32'h0);
    endtask
    task automatic t_dash;
        menu(MENU_UP_THR);
        press(1'h1, 1'h0, 10);
        chk("disp", {29'h0, DISP_DASH}, {29'h0, disp_code});
        rel;
        apb(1'h0, ADDR_SETTINGS, 32'h0);
        chk("settings", 32'h00001450, rd);
    endtask
    task automatic t_mode(input logic i, input logic d, input tsls_disp_t c,
                          input logic [1:0] st, input logic [15:0] hl, input logic [15:0] al);
        menu(MENU_MODE);
        press(i, d, SEC + 20);
        chk("disp", {29'h0, c}, {29'h0, disp_code});
        chk_loop(hl);
        rel;
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("mode", {30'h0, st}, {30'h0, rd[1:0]});
        chk_loop(al);
        chk("disp", {29'h0, DISP_VALUE}, {29'h0, disp_code});
        chk("disp_value", {16'h0, al}, {16'h0, disp_value});
    endtask
    task automatic t_settings;
        menu(MENU_UP_THR);
        press(1'h0, 1'h1, 10);
        rel;
        menu(MENU_LO_THR);
        press(1'h1, 1'h0, 75);
        rel;
        menu(MENU_UP_DLY);
        press(1'h1, 1'h1, 30);
        rel;
        apb(1'h0, ADDR_SETTINGS, 32'h0);
        chk("upper", 32'h4f, {25'h0, rd[6:0]});
        chk("repeat", 32'h1, {31'h0, rd[14:8] > 7'h15});
        chk("delays", 32'h00000064, {17'h0, rd[30:24], 1'h0, rd[22:16]});
        chk("disp_value", 32'h00000064, {16'h0, disp_value});
    endtask
    task automatic t_cover;
        level_set <= 16'sh0320;
        wt(5000);
        level_set <= 16'sh01f4;
        wt(20);
        chk("covered", 32'h0, {31'h0, covered});
        level_set <= 16'sh0320;
        wt(9800);
        chk("covered", 32'h0, {31'h0, covered});
        wait_cov(1'h1, 400);
        wt(3);
        chk_loop(UA_20);
        level_set <= 16'sh0064;
        wait_cov(1'h0, 20);
        wt(3);
        chk_loop(UA_4);
    endtask
    task automatic t_fault;
        apb(1'h1, ADDR_CTRL, 32'h2);
        fault_set <= 1'h1;
        wt(5);
        chk_loop(UA_FAULT_HI);
        apb(1'h1, ADDR_CTRL, 32'h4);
        wt(5);
        chk_loop(UA_FAULT_LO);
        fault_set <= 1'h0;
        apb(1'h1, ADDR_CTRL, 32'h0);
        wt(5);
        chk_loop(UA_20);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            test_done;
        end
    end
    initial begin
        wt(4);
        presetn <= 1'h1;
        wt(6);
        t_reset;
        t_analog;
        t_dash;
        level_set <= 16'sh01f4;
        t_mode(1'h1, 1'h0, DISP_C_HI, 2'h1, 16'h2ee0, UA_4);
        t_settings;
        t_cover;
        t_mode(1'h0, 1'h1, DISP_C_LO, 2'h2, UA_4, UA_20);
        t_fault;
        level_set <= 16'sh01f4;
        t_mode(1'h1, 1'h1, DISP_C_AN, 2'h0, 16'h2ee0, 16'h2ee0);
        test_done;
    end
endmodule

`default_nettype wire

// >>> tb/tsls_probe_model.sv
`timescale 1ns/1ps
`default_nettype none

module tsls_probe_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Wanted level and fault
    input wire logic signed [15:0] level_set,
    input wire logic fault_set,
    // Measurement to the block
    output logic signed [15:0] level_pmil,
    output logic fault
);
    // One cycle of measurement latency, like a sampled probe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_pmil <= 16'sh0000;
            fault <= 1'h0;
        end else begin
            level_pmil <= level_set;
            fault <= fault_set;
        end
    end
endmodule

`default_nettype wire

// >>> tb/tsls_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module tsls_top_assertions import tsls_pkg::*; #(
    parameter int unsigned SEC_CYCLES = SEC_CYC_DEF
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Measurement and panel
    input wire logic signed [15:0] level_pmil,
    input wire logic fault,
    input wire logic btn_inc_n,
    input wire logic btn_dec_n,
    input wire logic [3:0] menu_sel,
    // Outputs
    input wire logic [15:0] loop_ua,
    input wire logic covered,
    input wire tsls_disp_t disp_code
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    logic mapped;
    logic [1:0] fsig_q;
    int both_cnt;
    int inc_cnt;
    assign acc = psel && penable;
    assign mapped = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_SETTINGS, ADDR_LOOP};
    // Shadow of the fault-signalling field, from completed writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsig_q <= 2'h0;
        end else if (acc && pwrite && paddr == ADDR_CTRL) begin
            fsig_q <= pwdata[2:1];
        end
    end
    // Length of the present hold: both buttons, or increment alone on the mode item
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            both_cnt <= 0;
            inc_cnt <= 0;
        end else begin
            both_cnt <= (!btn_inc_n && !btn_dec_n) ? both_cnt + 1 : 0;
            inc_cnt <= (!btn_inc_n && btn_dec_n && menu_sel == MENU_MODE) ? inc_cnt + 1 : 0;
        end
    end
    a_ready_high: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_sat_span: assert property (!fault [*3] |-> loop_ua >= UA_SAT_LO && loop_ua <= UA_SAT_HI)
        else $error("loop current outside saturation limits");
    a_fault_high: assert property ((fault && fsig_q == FSIG_HI) [*3] |-> loop_ua == UA_FAULT_HI)
        else $error("high fault current not driven");
    a_fault_low: assert property ((fault && fsig_q == FSIG_LO) [*3] |-> loop_ua == UA_FAULT_LO)
        else $error("low fault current not driven");
    a_cover_rise: assert property ($rose(covered) |-> $past(level_pmil) > 16'sh0000)
        else $error("covered set with level at or below zero");
    a_cover_fall: assert property ($fell(covered) |-> $past(level_pmil) < 16'sh03e8)
        else $error("covered cleared with level at full range");
    a_analog_code: assert property (both_cnt == SEC_CYCLES + 12 |-> disp_code == DISP_C_AN)
        else $error("analog code not shown on long both-button hold");
    a_high_code: assert property (inc_cnt == SEC_CYCLES + 12 |-> disp_code == DISP_C_HI)
        else $error("high code not shown on long increment hold");
endmodule

bind tsls_top tsls_top_assertions #(.SEC_CYCLES(SEC_CYCLES)) u_tsls_top_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .level_pmil(level_pmil), .fault(fault), .btn_inc_n(btn_inc_n), .btn_dec_n(btn_dec_n),
    .menu_sel(menu_sel), .loop_ua(loop_ua), .covered(covered), .disp_code(disp_code)
);

`default_nettype wire
